/* File: design/uecs_defines.vh */
`ifndef UECS_DEFINES_VH
`define UECS_DEFINES_VH

// ------------------------------------------------------------
// register offsets
// ------------------------------------------------------------
`define UECS_ADDR_W        8
`define UECS_OFS_ENADDR    8'h10
`define UECS_OFS_EVT1      8'h11
`define UECS_OFS_EVT2      8'h12
`define UECS_OFS_CTRL      8'h13
`define UECS_OFS_EP0STAT   8'h14
`define UECS_OFS_EP0TX     8'h15
`define UECS_OFS_MASK1     8'h16
`define UECS_OFS_MASK2     8'h17

// ------------------------------------------------------------
// field positions
// ------------------------------------------------------------
`define UECS_B_ENABLE      7
`define UECS_B_RX0         7
`define UECS_B_TX0         6
`define UECS_B_TX1         5
`define UECS_B_TX2         4
`define UECS_B_BRST        3
`define UECS_B_SUSP        2
`define UECS_B_RSM         3
`define UECS_B_T0          0
`define UECS_B_FSUSP       7
`define UECS_B_RRES        6
`define UECS_B_RXRDY       0
`define UECS_B_TGL         7
`define UECS_B_DIR         5
`define UECS_B_SETUP       4
`define UECS_B_TXRDY       7

// ------------------------------------------------------------
// masks and reset values
// ------------------------------------------------------------
`define UECS_EVT1_MASK     8'hfc
`define UECS_EVT2_MASK     8'h09
`define UECS_CTRL_MASK     8'hc1
`define UECS_ZERO8         8'h00
`define UECS_ZERO7         7'h00
`define UECS_ADDR_MSB      6

`endif

/* File: design/uecs_core.v */
// The plain strobed port was decided locally.
`timescale 1ns/1ps
`include "uecs_defines.vh"

// How it works
// - engine disabled while enable bit is 0; operates once set to 1.
// - seven-bit function address held; only matching tokens accepted.
// - ep0 receive event set on rx completion; cleared by writing 0.
// - ep0 transmit event set on tx completion; cleared by writing 0.
// - ep1 transmit event set on IN completion; cleared by writing 0.
// - ep2 transmit event set on IN completion; cleared by writing 0.
// - bus reset event set on detected bus reset; cleared by writing 0.
// - suspend event set when bus suspends; cleared by writing 0.
// - resume event set on resume signalling; cleared by writing 0.
// - timer zero event flag in second event register; write 0 clears.
// - forced-suspend bit puts the interface into suspend.
// - remote resume drives resume signalling while suspended.
// - receive-ready set by firmware; hardware clears it with rx event.
// - read-only toggle of last ep0 received packet, 1 for DATA1.
// - read-only ep0 direction bit, 1 for IN.
// - read-only indicator that last ep0 token was SETUP.
// - transmit-ready set by firmware; hardware clears it with tx event.
module uecs_core (
	input  wire       sys_clk,
	input  wire       rst,
	input  wire [7:0] reg_addr,
	input  wire [7:0] reg_wdata,
	input  wire       reg_wr,
	input  wire       reg_rd,
	output reg  [7:0] reg_rdata,
	input  wire       sie_token_valid,
	input  wire [6:0] sie_token_addr,
	input  wire       sie_token_setup,
	input  wire       sie_token_in,
	input  wire       sie_ep0_rx_done,
	input  wire       sie_ep0_rx_data1,
	input  wire       sie_ep0_tx_done,
	input  wire       sie_ep1_tx_done,
	input  wire       sie_ep2_tx_done,
	input  wire       sie_bus_reset,
	input  wire       sie_suspend,
	input  wire       sie_resume,
	input  wire       timer_zero_tick,
	output reg        engine_on,
	output reg        addr_match,
	output reg        suspend_active,
	output reg        remote_resume_drive,
	output reg        ep0_receive_ready,
	output reg        ep0_transmit_ready,
	output reg        irq
);

// ------------------------------------------------------------
// registers
// ------------------------------------------------------------
reg        engine_enable_r;
reg  [6:0] function_address_r;
reg  [7:0] evt1_r;
reg  [7:0] evt2_r;
reg  [7:0] evt1_nxt;
reg  [7:0] evt2_nxt;
reg  [7:0] mask1_r;
reg  [7:0] mask2_r;
reg        force_susp_r;
reg        remote_res_r;
reg        rx_ready_r;
reg        tx_ready_r;
reg        rx_toggle_r;
reg        dir_r;
reg        setup_seen_r;
reg  [7:0] rdata_nxt;
wire [7:0] evt1_set;
wire [7:0] evt2_set;
wire       live;
wire       susp_now;

// decode used for every register write
function wr_hit;
	input [7:0] a;
	input [7:0] ofs;
	input       w;
	begin
		wr_hit = w && (a == ofs);
	end
endfunction

// events are ignored while the engine is off; timer ticks are not usb
assign live = engine_enable_r;
assign evt1_set = {live & sie_ep0_rx_done, live & sie_ep0_tx_done,
	live & sie_ep1_tx_done, live & sie_ep2_tx_done,
	live & sie_bus_reset, live & sie_suspend, 2'b00};
assign evt2_set = {4'h0, live & sie_resume, 2'b00, timer_zero_tick};
assign susp_now = live && (force_susp_r || evt1_r[`UECS_B_SUSP]);

// ------------------------------------------------------------
// sticky flags: write 0 clears, write 1 keeps, set beats clear
// ------------------------------------------------------------
always @* begin
	evt1_nxt = evt1_r;
	evt2_nxt = evt2_r;
	if (wr_hit(reg_addr, `UECS_OFS_EVT1, reg_wr))
		evt1_nxt = evt1_r & reg_wdata;
	if (wr_hit(reg_addr, `UECS_OFS_EVT2, reg_wr))
		evt2_nxt = evt2_r & reg_wdata;
	evt1_nxt = (evt1_nxt | evt1_set) & `UECS_EVT1_MASK;
	evt2_nxt = (evt2_nxt | evt2_set) & `UECS_EVT2_MASK;
end

always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		engine_enable_r    <= 1'b0;
		function_address_r <= `UECS_ZERO7;
		evt1_r             <= `UECS_ZERO8;
		evt2_r             <= `UECS_ZERO8;
		mask1_r            <= `UECS_ZERO8;
		mask2_r            <= `UECS_ZERO8;
		force_susp_r       <= 1'b0;
		remote_res_r       <= 1'b0;
		rx_ready_r         <= 1'b0;
		tx_ready_r         <= 1'b0;
		rx_toggle_r        <= 1'b0;
		dir_r              <= 1'b0;
		setup_seen_r       <= 1'b0;
	end else begin
		evt1_r <= evt1_nxt;
		evt2_r <= evt2_nxt;
		if (wr_hit(reg_addr, `UECS_OFS_ENADDR, reg_wr)) begin
			engine_enable_r    <= reg_wdata[`UECS_B_ENABLE];
			function_address_r <= reg_wdata[`UECS_ADDR_MSB:0];
		end
		if (wr_hit(reg_addr, `UECS_OFS_MASK1, reg_wr))
			mask1_r <= reg_wdata & `UECS_EVT1_MASK;
		if (wr_hit(reg_addr, `UECS_OFS_MASK2, reg_wr))
			mask2_r <= reg_wdata & `UECS_EVT2_MASK;
		if (wr_hit(reg_addr, `UECS_OFS_CTRL, reg_wr)) begin
			force_susp_r <= reg_wdata[`UECS_B_FSUSP];
			remote_res_r <= reg_wdata[`UECS_B_RRES];
		end
		// hardware clear wins over a same-cycle firmware set
		if (evt1_set[`UECS_B_RX0])
			rx_ready_r <= 1'b0;
		else if (wr_hit(reg_addr, `UECS_OFS_CTRL, reg_wr))
			rx_ready_r <= reg_wdata[`UECS_B_RXRDY];
		if (evt1_set[`UECS_B_TX0])
			tx_ready_r <= 1'b0;
		else if (wr_hit(reg_addr, `UECS_OFS_EP0TX, reg_wr))
			tx_ready_r <= reg_wdata[`UECS_B_TXRDY];
		if (evt1_set[`UECS_B_RX0])
			rx_toggle_r <= sie_ep0_rx_data1;
		if (live && sie_token_valid &&
		    sie_token_addr == function_address_r) begin
			dir_r        <= sie_token_in;
			setup_seen_r <= sie_token_setup;
		end
	end
end

// ------------------------------------------------------------
// read mux, data one cycle after the strobe
// ------------------------------------------------------------
always @* begin
	rdata_nxt = `UECS_ZERO8;
	case (reg_addr)
	`UECS_OFS_ENADDR:  rdata_nxt = {engine_enable_r, function_address_r};
	`UECS_OFS_EVT1:    rdata_nxt = evt1_r;
	`UECS_OFS_EVT2:    rdata_nxt = evt2_r;
	`UECS_OFS_CTRL:    rdata_nxt = {force_susp_r, remote_res_r, 5'h00,
		rx_ready_r};
	`UECS_OFS_EP0STAT: rdata_nxt = {rx_toggle_r, 1'b0, dir_r,
		setup_seen_r, 4'h0};
	`UECS_OFS_EP0TX:   rdata_nxt = {tx_ready_r, 7'h00};
	`UECS_OFS_MASK1:   rdata_nxt = mask1_r;
	`UECS_OFS_MASK2:   rdata_nxt = mask2_r;
	default:           rdata_nxt = `UECS_ZERO8;
	endcase
end

// ------------------------------------------------------------
// registered outputs
// ------------------------------------------------------------
always @(posedge sys_clk or posedge rst) begin
	if (rst) begin
		reg_rdata           <= `UECS_ZERO8;
		engine_on           <= 1'b0;
		addr_match          <= 1'b0;
		suspend_active      <= 1'b0;
		remote_resume_drive <= 1'b0;
		ep0_receive_ready   <= 1'b0;
		ep0_transmit_ready  <= 1'b0;
		irq                 <= 1'b0;
	end else begin
		// unmapped or idle reads return zero
		reg_rdata <= reg_rd ? rdata_nxt : `UECS_ZERO8;
		engine_on <= live;
		// token address compare; off engine answers nothing
		addr_match <= live && sie_token_valid &&
			(sie_token_addr == function_address_r);
		suspend_active <= susp_now;
		// resume only makes sense while suspended
		remote_resume_drive <= susp_now && remote_res_r;
		ep0_receive_ready   <= rx_ready_r;
		ep0_transmit_ready  <= tx_ready_r;
		// flags use next value so irq tracks them without extra lag
		irq <= |(evt1_nxt & mask1_r) || |(evt2_nxt & mask2_r);
	end
end

endmodule // uecs_core

/* File: test/uecs_asserts.sv */
`timescale 1ns/1ps
module uecs_asserts (
	input wire logic       sys_clk, rst, reg_wr, reg_rd, engine_on, irq,
	input wire logic       addr_match, sie_token_valid, sie_ep0_rx_done,
	input wire logic       sie_ep0_tx_done, ep0_receive_ready,
	input wire logic       ep0_transmit_ready,
	input wire logic [7:0] reg_addr, reg_wdata, reg_rdata,
	input wire logic [6:0] sie_token_addr
);
	logic [6:0] adr_r;
	logic       msk_r;
	// mirrors of address and rx mask, so match and irq have a cause to face
	always @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			adr_r <= 7'h00;
			msk_r <= 1'b0;
		end else if (reg_wr && reg_addr == 8'h10)
			adr_r <= reg_wdata[6:0];
		else if (reg_wr && reg_addr == 8'h16)
			msk_r <= reg_wdata[7];
	end
	default clocking @(posedge sys_clk); endclocking
	default disable iff (rst);
	a_enable_follow: assert property (reg_wr && reg_addr == 8'h10 |->
		##2 engine_on == $past(reg_wdata[7], 2)) else $error("enable lost");
	a_disabled_deaf: assert property (sie_token_valid && !engine_on
		|=> !addr_match) else $error("match while off");
	a_match_token: assert property (sie_token_valid && engine_on &&
		sie_token_addr == adr_r |=> addr_match) else $error("no match");
	a_rx_rdy_clear: assert property (sie_ep0_rx_done && engine_on
		|-> ##2 !ep0_receive_ready) else $error("rx ready kept");
	a_tx_rdy_clear: assert property (sie_ep0_tx_done && engine_on
		|-> ##2 !ep0_transmit_ready) else $error("tx ready kept");
	a_irq_raise: assert property (sie_ep0_rx_done && engine_on && msk_r
		|=> irq) else $error("irq not raised");
	a_irq_hold: assert property (irq && !reg_wr && !$past(reg_wr)
		|=> irq) else $error("irq dropped alone");
	a_rdata_idle: assert property (!$past(reg_rd)
		|-> reg_rdata == 8'h00) else $error("read data outside slot");
	cover property (sie_ep0_rx_done && engine_on);
	cover property (irq);
	cover property (addr_match);
endmodule // uecs_asserts
bind uecs_core uecs_asserts chk_u (.*);

/* File: test/uecs_host_model.sv */
`timescale 1ns/1ps
// serial engine facing the host; released data lines show inverted values, strobes return to 0
module uecs_host_model (
	input  wire logic       sys_clk,
	output wire logic       sie_ep0_rx_done, sie_ep0_tx_done, sie_ep1_tx_done,
	output wire logic       sie_ep2_tx_done, sie_bus_reset, sie_suspend,
	output wire logic       sie_resume, timer_zero_tick,
	output logic            sie_token_valid = 1'b0, sie_ep0_rx_data1 = 1'b0,
	output logic            sie_token_setup = 1'b0, sie_token_in = 1'b0,
	output logic      [6:0] sie_token_addr = 7'h00
);
	logic [7:0] ev = 8'h00;
	assign {timer_zero_tick, sie_resume, sie_suspend, sie_bus_reset,
		sie_ep2_tx_done, sie_ep1_tx_done, sie_ep0_tx_done,
		sie_ep0_rx_done} = ev;
	task automatic event_pulse(input int i, input logic d);
		@(posedge sys_clk);
		ev <= 8'h01 << i;
		sie_ep0_rx_data1 <= d;
		@(posedge sys_clk);
		ev <= 8'h00;
		sie_ep0_rx_data1 <= ~d;
	endtask
	task automatic token(input logic [6:0] a, input logic s, input logic n);
		@(posedge sys_clk);
		sie_token_valid <= 1'b1;
		sie_token_addr <= a;
		{sie_token_setup, sie_token_in} <= {s, n};
		@(posedge sys_clk);
		sie_token_valid <= 1'b0;
		sie_token_addr <= ~a;
		{sie_token_setup, sie_token_in} <= {~s, ~n};
	endtask
endmodule // uecs_host_model

/* File: test/usb_engine_control_status_bench.sv */
`timescale 1ns/1ps
module usb_engine_control_status_bench;
	logic       sys_clk = 1'b0, rst = 1'b1, reg_wr = 1'b0, reg_rd = 1'b0;
	logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, a, b;
	wire  [7:0] reg_rdata;
	wire  [6:0] sie_token_addr;
	wire        sie_token_valid, sie_token_setup, sie_token_in, sie_resume;
	wire        sie_ep0_rx_done, sie_ep0_rx_data1, sie_ep0_tx_done, irq;
	wire        sie_ep1_tx_done, sie_ep2_tx_done, sie_bus_reset, sie_suspend;
	wire        timer_zero_tick, engine_on, addr_match, suspend_active;
	wire        remote_resume_drive, ep0_receive_ready, ep0_transmit_ready;
	int         num_errors = 0, comparisons = 0;
	uecs_core dut_u (.*);
	uecs_host_model host_u (.*);
	task automatic check(input logic [7:0] got, input logic [7:0] exp);
		comparisons++;
		if (got !== exp) begin
			num_errors++;
			$display("CHECK FAILED %0t got %h want %h", $time, got, exp);
		end
	endtask
	task automatic wr(input logic [7:0] ad, input logic [7:0] d);
		@(posedge sys_clk);
		{reg_addr, reg_wdata, reg_wr} <= {ad, d, 1'b1};
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask
	task automatic rd(input logic [7:0] ad, input logic [7:0] exp);
		@(posedge sys_clk);
		{reg_addr, reg_rd} <= {ad, 1'b1};
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		#1 check(reg_rdata, exp);
	endtask
	task automatic final_report();
		$display("errors %0d comparisons %0d", num_errors, comparisons);
		if (num_errors == 0 && comparisons > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	initial forever #2.5 sys_clk = ~sys_clk;
	// generous: the whole sequence needs well under a thousand cycles
	initial begin
		#50000;
		num_errors++;
		final_report();
	end
	initial begin
		repeat (2) @(posedge sys_clk);
		rst <= 1'b0;
		for (int k = 16; k < 24; k++) rd(k[7:0], 8'h00);
		rd(8'h20, 8'h00);
		$display("reset test done");
		host_u.event_pulse(0, 1'b0);
		rd(8'h11, 8'h00);
		wr(8'h10, 8'h85);
		rd(8'h10, 8'h85);
		check({7'h00, engine_on}, 8'h01);
		wr(8'h16, 8'hff);
		wr(8'h17, 8'hff);
		host_u.token(7'h05, 1'b1, 1'b0);
		#1 check({7'h00, addr_match}, 8'h01);
		rd(8'h14, 8'h10);
		host_u.token(7'h05, 1'b0, 1'b1);
		rd(8'h14, 8'h20);
		host_u.token(7'h06, 1'b1, 1'b0);
		#1 check({7'h00, addr_match}, 8'h00);
		rd(8'h14, 8'h20);
		$display("token test done");
		for (int i = 0; i < 8; i++) begin
			wr(8'h13, 8'h01);
			wr(8'h15, 8'h80);
			host_u.event_pulse(i, 1'b1);
			a = (i < 6) ? 8'h11 : 8'h12;
			b = (i < 6) ? 8'h80 >> i : ((i == 6) ? 8'h08 : 8'h01);
			rd(a, b);
			check({7'h00, irq}, 8'h01);
			wr(a, 8'hff);
			rd(a, b);
			wr(a, ~b);
			rd(a, 8'h00);
			check({7'h00, irq}, 8'h00);
			rd(8'h13, (i == 0) ? 8'h00 : 8'h01);
			check({7'h00, ep0_receive_ready}, (i == 0) ? 8'h00 : 8'h01);
			rd(8'h15, (i == 1) ? 8'h00 : 8'h80);
			check({7'h00, ep0_transmit_ready}, (i == 1) ? 8'h00 : 8'h01);
		end
		rd(8'h14, 8'ha0);
		$display("event test done");
		wr(8'h13, 8'hc0);
		@(posedge sys_clk);
		#1 check({suspend_active, remote_resume_drive}, 8'h03);
		$display("suspend test done");
		final_report();
	end
endmodule // usb_engine_control_status_bench
